// [hdl/sectc_core.sv]
// Second timer core: prescaler, counter, flags and Wishbone registers.
`timescale 1ns/1ps
module sectc_core (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [7:0]              adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  output logic                         err_o,
  input  wire logic                    wait_mode_i,
  input  wire logic                    stop_mode_i,
  input  wire logic                    break_i,
  input  wire logic                    break_flag_clear_enable_i,
  input  wire sectc_pkg::sectc_chev_t  chan_event_i,
  output logic      [15:0]             count_o,
  output logic                         overflow_o,
  output sectc_pkg::sectc_chcfg_t      chan0_cfg_o,
  output sectc_pkg::sectc_chcfg_t      chan1_cfg_o,
  output logic                         ovf_irq_o,
  output logic      [1:0]              chan_irq_o,
  output logic                         wake_o
);
  logic [15:0] count_r;
  logic [5:0]  pre_r;
  logic [15:0] mod_r;
  logic        mod_inhibit_r;
  logic        ovf_flag_r;
  logic        ovf_arm_r;
  logic        ovf_ie_r;
  logic        halt_r;
  logic [2:0]  div_r;
  logic [7:0]  low_latch_r;
  logic        latched_r;
  logic [1:0]  ch_flag_r;
  logic [1:0]  ch_arm_r;
  logic [1:0]  ch_ie_r;
  sectc_pkg::sectc_chcfg_t ch_cfg_r [2];
  sectc_pkg::sectc_bus_t   bus_r;
  logic [31:0] dat_r;

  logic [5:0]  idx;
  logic        req;
  logic        mapped;
  logic        wr;
  logic        rd;
  logic [7:0]  wbyte;
  logic        flag_clr_ok;
  logic        running;
  logic [5:0]  pre_mask;
  logic        tick;
  logic        wrap;
  logic        ovf_event;
  logic        clr_cmd;
  logic [1:0]  ch_event;
  logic [7:0]  sc_read;
  logic [7:0]  rdata;

  assign idx   = adr_i[7:2];
  assign wbyte = dat_i[7:0];
  assign req   = cyc_i && stb_i && (bus_r == sectc_pkg::BUS_IDLE);
  assign mapped = (idx >= sectc_pkg::IDX_STATUS_CTRL) &&
                  (idx <= sectc_pkg::IDX_CHAN1_CTRL);
  // Accesses in wait mode are answered with an error and change nothing.
  assign wr = req && mapped && we_i && sel_i[0] && !wait_mode_i;
  assign rd = req && mapped && !we_i && !wait_mode_i;
  // With break active and the enable low, flags are protected.
  assign flag_clr_ok = !break_i || break_flag_clear_enable_i;

  // The stop input freezes even the prescaler, so the count is preserved.
  assign running = !halt_r && !break_i && !stop_mode_i;
  // Prescaler runs from the bus clock only; the mask picks the divide ratio.
  assign pre_mask = 6'(({1'b0, sectc_pkg::PRE_ONE} << div_r) -
                       7'h01);
  assign tick = running && (div_r != sectc_pkg::DIV_UNUSED) &&
                ((pre_r & pre_mask) == pre_mask);
  assign wrap = tick && (count_r == mod_r);
  assign ovf_event = wrap && !mod_inhibit_r;
  assign clr_cmd = wr && (idx == sectc_pkg::IDX_STATUS_CTRL) &&
                   wbyte[sectc_pkg::SC_CLR];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_r <= sectc_pkg::PRE_ZERO;
    end else if (clr_cmd) begin
      pre_r <= sectc_pkg::PRE_ZERO;
    end else if (running) begin
      pre_r <= pre_r + sectc_pkg::PRE_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= sectc_pkg::COUNT_RESET;
    end else if (clr_cmd) begin
      count_r <= sectc_pkg::COUNT_RESET;
    end else if (wrap) begin
      count_r <= sectc_pkg::COUNT_RESET;
    end else if (tick) begin
      count_r <= count_r + sectc_pkg::COUNT_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_r         <= sectc_pkg::MOD_RESET;
      mod_inhibit_r <= 1'b0;
    end else if (wr && idx == sectc_pkg::IDX_MOD_HIGH) begin
      mod_r[15:8]   <= wbyte;
      mod_inhibit_r <= 1'b1;
    end else if (wr && idx == sectc_pkg::IDX_MOD_LOW) begin
      mod_r[7:0]    <= wbyte;
      mod_inhibit_r <= 1'b0;
    end
  end

  // Control bits of the status register; the clear bit is never stored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_ie_r <= 1'b0;
      halt_r   <= 1'b1;
      div_r    <= sectc_pkg::DIV_RESET;
    end else if (wr && idx == sectc_pkg::IDX_STATUS_CTRL) begin
      ovf_ie_r <= wbyte[sectc_pkg::SC_OVIE];
      halt_r   <= wbyte[sectc_pkg::SC_HALT];
      div_r    <= wbyte[sectc_pkg::SC_DIVH -: 3];
    end
  end

  // Overflow flag: a new overflow wins over a clear in the same cycle and
  // disarms a pending clear, so no request is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_flag_r <= 1'b0;
      ovf_arm_r  <= 1'b0;
    end else if (ovf_event) begin
      ovf_flag_r <= 1'b1;
      ovf_arm_r  <= 1'b0;
    end else if (rd && idx == sectc_pkg::IDX_STATUS_CTRL && ovf_flag_r &&
                 flag_clr_ok) begin
      ovf_arm_r  <= 1'b1;
    end else if (wr && idx == sectc_pkg::IDX_STATUS_CTRL && ovf_arm_r &&
                 flag_clr_ok && !wbyte[sectc_pkg::SC_OVF]) begin
      ovf_flag_r <= 1'b0;
      ovf_arm_r  <= 1'b0;
    end
  end

  // Captures are dropped while halted or in break; compares pass.
  assign ch_event = (chan_event_i.capture & {2{!halt_r && !break_i}}) |
                    chan_event_i.compare;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      localparam logic [5:0] CH_IDX = sectc_pkg::IDX_CHAN0_CTRL + 6'(g);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ch_flag_r[g] <= 1'b0;
          ch_arm_r[g]  <= 1'b0;
        end else if (ch_event[g]) begin
          ch_flag_r[g] <= 1'b1;
          ch_arm_r[g]  <= 1'b0;
        end else if (rd && idx == CH_IDX && ch_flag_r[g] && flag_clr_ok) begin
          ch_arm_r[g]  <= 1'b1;
        end else if (wr && idx == CH_IDX && ch_arm_r[g] && flag_clr_ok &&
                     !wbyte[sectc_pkg::CH_FLAG]) begin
          ch_flag_r[g] <= 1'b0;
          ch_arm_r[g]  <= 1'b0;
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ch_ie_r[g]  <= 1'b0;
          ch_cfg_r[g] <= '0;
        end else if (wr && idx == CH_IDX) begin
          ch_ie_r[g]  <= wbyte[sectc_pkg::CH_IE];
          ch_cfg_r[g] <= wbyte[5:0];
        end
      end
      assign chan_irq_o[g] = ch_flag_r[g] && ch_ie_r[g];
    end
  endgenerate

  // Low byte latch: only the first high read since reset or the last low read captures.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_latch_r <= 8'h00;
      latched_r   <= 1'b0;
    end else if (rd && idx == sectc_pkg::IDX_COUNT_HIGH && !latched_r) begin
      low_latch_r <= count_r[7:0];
      latched_r   <= 1'b1;
    end else if (rd && idx == sectc_pkg::IDX_COUNT_LOW) begin
      latched_r   <= 1'b0;
    end
  end

  assign sc_read = {ovf_flag_r, ovf_ie_r, halt_r, 1'b0, 1'b0, div_r};

  always_comb begin
    rdata = 8'h00;
    case (idx)
      sectc_pkg::IDX_STATUS_CTRL: rdata = sc_read;
      sectc_pkg::IDX_COUNT_HIGH:  rdata = count_r[15:8];
      sectc_pkg::IDX_COUNT_LOW:   rdata = latched_r ? low_latch_r
                                                    : count_r[7:0];
      sectc_pkg::IDX_MOD_HIGH:    rdata = mod_r[15:8];
      sectc_pkg::IDX_MOD_LOW:     rdata = mod_r[7:0];
      sectc_pkg::IDX_CHAN0_CTRL:  rdata = {ch_flag_r[0], ch_ie_r[0],
                                           ch_cfg_r[0]};
      sectc_pkg::IDX_CHAN1_CTRL:  rdata = {ch_flag_r[1], ch_ie_r[1],
                                           ch_cfg_r[1]};
      default:                    rdata = 8'h00;
    endcase
  end

  // Bus slave: answer one cycle after the request, then one idle cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_r <= sectc_pkg::BUS_IDLE;
      dat_r <= 32'h00000000;
    end else begin
      case (bus_r)
        sectc_pkg::BUS_IDLE: begin
          if (req) begin
            bus_r <= (mapped && !wait_mode_i) ? sectc_pkg::BUS_ACK
                                              : sectc_pkg::BUS_ERR;
            dat_r <= rd ? {24'h000000, rdata} : 32'h00000000;
          end
        end
        default: begin
          bus_r <= sectc_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  assign ack_o = (bus_r == sectc_pkg::BUS_ACK);
  assign err_o = (bus_r == sectc_pkg::BUS_ERR);
  assign dat_o = dat_r;
  assign count_o = count_r;
  assign chan0_cfg_o = ch_cfg_r[0];
  assign chan1_cfg_o = ch_cfg_r[1];

  // Overflow pulse registered so outside channel logic sees a clean strobe.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_o <= 1'b0;
    end else begin
      overflow_o <= wrap;
    end
  end

  assign ovf_irq_o = ovf_flag_r && ovf_ie_r && !mod_inhibit_r;
  assign wake_o = ovf_irq_o || (|chan_irq_o);

  // Checks.
  sequence s_read_flag;
    rd && idx == sectc_pkg::IDX_STATUS_CTRL && ovf_flag_r && flag_clr_ok;
  endsequence
  sequence s_write_zero;
    wr && idx == sectc_pkg::IDX_STATUS_CTRL && !wbyte[sectc_pkg::SC_OVF];
  endsequence

  a_ovf_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_event |=> ovf_flag_r)
    else $error("overflow flag not set on modulo match");
  a_ovf_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_irq_o |-> (ovf_flag_r && ovf_ie_r))
    else $error("overflow irq without flag and enable");
  a_chan_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    chan_event_i.compare[0] |=> ch_flag_r[0])
    else $error("channel flag not set on compare");
  a_wait_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wait_mode_i) |=> err_o && !ack_o)
    else $error("access accepted in wait mode");
  a_stop_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    (stop_mode_i && !clr_cmd) |=> $stable(count_r) && $stable(pre_r))
    else $error("timer moved in stop mode");
  a_break_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (break_i && !break_flag_clear_enable_i && ovf_flag_r) |=> ovf_flag_r)
    else $error("flag cleared during protected break");
  a_two_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_read_flag and !ovf_event) ##1 (!ovf_event) [*2] ##1
    (s_write_zero and (flag_clr_ok && !ovf_event)) |=> !ovf_flag_r)
    else $error("two-step clear failed");
  a_halt_still: assert property (@(posedge clk_i) disable iff (rst_i)
    (halt_r && !clr_cmd) |=> $stable(count_r))
    else $error("counter advanced while halted");
  a_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    clr_cmd |=> count_r == sectc_pkg::COUNT_RESET &&
                pre_r == sectc_pkg::PRE_ZERO)
    else $error("clear did not zero counter");
  a_wrap_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (wrap && !clr_cmd) |=> count_r == sectc_pkg::COUNT_RESET && overflow_o)
    else $error("counter did not restart at zero");
  a_latch_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (latched_r && !(rd && idx == sectc_pkg::IDX_COUNT_LOW))
      |=> latched_r && $stable(low_latch_r))
    else $error("latched low byte changed");
endmodule

// [hdl/sectc_pkg.sv]
// Package with register map, field positions and types of the second timer.
package sectc_pkg;
  localparam int CLK_HZ = 10000000;
  // Register indices; byte address is four times the index.
  localparam logic [5:0] IDX_STATUS_CTRL = 6'h2B;
  localparam logic [5:0] IDX_COUNT_HIGH  = 6'h2C;
  localparam logic [5:0] IDX_COUNT_LOW   = 6'h2D;
  localparam logic [5:0] IDX_MOD_HIGH    = 6'h2E;
  localparam logic [5:0] IDX_MOD_LOW     = 6'h2F;
  localparam logic [5:0] IDX_CHAN0_CTRL  = 6'h30;
  localparam logic [5:0] IDX_CHAN1_CTRL  = 6'h31;
  // Status and control field positions.
  localparam int SC_OVF  = 7;
  localparam int SC_OVIE = 6;
  localparam int SC_HALT = 5;
  localparam int SC_CLR  = 4;
  localparam int SC_DIVH = 2;
  // Channel control field positions.
  localparam int CH_FLAG = 7;
  localparam int CH_IE   = 6;
  // Reset values, the unused divider code and increment constants.
  localparam logic [15:0] MOD_RESET   = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [2:0]  DIV_RESET   = 3'h0;
  localparam logic [2:0]  DIV_UNUSED  = 3'h7;
  localparam logic [5:0]  PRE_ZERO    = 6'h00;
  localparam logic [5:0]  PRE_ONE     = 6'h01;
  localparam logic [15:0] COUNT_ONE   = 16'h0001;

  typedef struct packed {
    logic       buffered;
    logic       mode_a;
    logic [1:0] edge_level;
    logic       toggle_ovf;
    logic       max_duty;
  } sectc_chcfg_t;

  typedef struct packed {
    logic [1:0] capture;
    logic [1:0] compare;
  } sectc_chev_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01,
    BUS_ERR  = 2'b10
  } sectc_bus_t;
endpackage

// [bench/testbench.sv]
// Self-checking testbench for the second timer core over Wishbone.
`timescale 1ns/1ps
module testbench;
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   cyc_i = 1'b0;
  logic                   stb_i = 1'b0;
  logic                   we_i = 1'b0;
  logic [7:0]             adr_i = 8'h00;
  logic [3:0]             sel_i = 4'h0;
  logic [31:0]            dat_i = 32'h0;
  logic [31:0]            dat_o;
  logic                   ack_o;
  logic                   err_o;
  logic                   wait_mode_i = 1'b0;
  logic                   stop_mode_i = 1'b0;
  logic                   break_i = 1'b0;
  logic                   bfce_i = 1'b0;
  sectc_pkg::sectc_chev_t chan_event_i = '0;
  logic [15:0]            count_o;
  logic                   overflow_o;
  sectc_pkg::sectc_chcfg_t c0_o;
  sectc_pkg::sectc_chcfg_t c1_o;
  logic                   ovf_irq_o;
  logic [1:0]             chan_irq_o;
  logic                   wake_o;
  int                     mismatches = 0;
  int                     total_checks = 0;
  logic [15:0]            tk;
  logic [15:0]            s;
  logic [7:0]             q;
  logic [7:0]             h;
  logic                   e;
  logic [5:0]             r6;
  int                     n;
  logic [7:0]             ra[7] = '{8'hAC, 8'hB0, 8'hB4, 8'hB8,
                                    8'hBC, 8'hC0, 8'hC4};
  logic [7:0]             rv[7] = '{8'h20, 8'h00, 8'h00, 8'hFF,
                                    8'hFF, 8'h00, 8'h00};

  always #50 clk_i = ~clk_i;

  sectc_core u_sectc_core (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .wait_mode_i(wait_mode_i),
    .stop_mode_i(stop_mode_i), .break_i(break_i),
    .break_flag_clear_enable_i(bfce_i), .chan_event_i(chan_event_i),
    .count_o(count_o), .overflow_o(overflow_o), .chan0_cfg_o(c0_o),
    .chan1_cfg_o(c1_o), .ovf_irq_o(ovf_irq_o), .chan_irq_o(chan_irq_o),
    .wake_o(wake_o)
  );

  task automatic chk(input logic [15:0] sn, input logic [15:0] ex,
                     input string m);
    total_checks++;
    if (sn !== ex) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, sn, ex);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // The count at the taking edge is kept so a latched byte can be predicted.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      if (k == 0) tk = count_o;
      k++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 20);
    q = dat_o[7:0];
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    chk(k < 20, 1'b1, "bus answer");
  endtask

  task automatic wait_ovf();
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (overflow_o !== 1'b1 && n < 2000);
    chk(n < 2000, 1'b1, "overflow seen");
  endtask

  task automatic stable(input string m);
    s = count_o;
    repeat (10) @(posedge clk_i);
    chk(count_o, s, m);
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    mismatches++;
    summarize();
  end

  initial begin
    void'($urandom(32'hF7E6A0AC));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, ra[i], 8'h00);
      chk(q, rv[i], "reset value");
    end
    $display("test reset done");
    wb(1'b1, 8'hB0, 8'h55);
    wb(1'b0, 8'hB0, 8'h00);
    chk(q, 8'h00, "count byte write");
    wb(1'b0, 8'h00, 8'h00);
    chk(e, 1'b1, "unmapped access");
    wait_mode_i <= 1'b1;
    wb(1'b0, 8'hAC, 8'h00);
    chk(e, 1'b1, "wait mode access");
    wait_mode_i <= 1'b0;
    chan_event_i <= '{capture: 2'b01, compare: 2'b00};
    @(posedge clk_i);
    chan_event_i <= '0;
    wb(1'b0, 8'hC0, 8'h00);
    chk(q[7], 1'b0, "capture while halted");
    $display("test access done");
    wb(1'b1, 8'hB8, 8'h00);
    wb(1'b1, 8'hBC, 8'h05);
    for (int d = 0; d < 7; d++) begin
      wb(1'b1, 8'hAC, 8'(d));
      wait_ovf();
      wait_ovf();
      chk(16'(n), 16'(6 << d), "overflow period");
    end
    wb(1'b1, 8'hAC, 8'h07);
    stable("unused divider");
    $display("test divider done");
    wb(1'b1, 8'hAC, 8'h46);
    wait_ovf();
    @(posedge clk_i);
    chk(ovf_irq_o, 1'b1, "overflow irq");
    wb(1'b0, 8'hAC, 8'h00);
    chk(q[7], 1'b1, "overflow flag");
    wb(1'b1, 8'hAC, 8'h46);
    wb(1'b0, 8'hAC, 8'h00);
    chk({q[7], ovf_irq_o}, 2'b00, "flag clear");
    wait_ovf();
    wb(1'b0, 8'hAC, 8'h00);
    wait_ovf();
    wb(1'b1, 8'hAC, 8'h46);
    wb(1'b0, 8'hAC, 8'h00);
    chk(q[7], 1'b1, "clear after new overflow");
    // First step of the clear is taken before break so it must survive.
    wb(1'b0, 8'hAC, 8'h00);
    break_i <= 1'b1;
    wb(1'b1, 8'hAC, 8'h66);
    wb(1'b0, 8'hAC, 8'h00);
    chk(q[7], 1'b1, "clear in protected break");
    break_i <= 1'b0;
    wb(1'b1, 8'hAC, 8'h66);
    wb(1'b0, 8'hAC, 8'h00);
    chk(q[7], 1'b0, "second step after break");
    $display("test flag done");
    wb(1'b1, 8'hAC, 8'h40);
    break_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    stable("counter in break");
    break_i <= 1'b0;
    wait_ovf();
    break_i <= 1'b1;
    bfce_i  <= 1'b1;
    wb(1'b0, 8'hAC, 8'h00);
    wb(1'b1, 8'hAC, 8'h60);
    break_i <= 1'b0;
    bfce_i  <= 1'b0;
    wb(1'b0, 8'hAC, 8'h00);
    chk(q, 8'h60, "cleared in break stays");
    $display("test break done");
    wb(1'b1, 8'hAC, 8'h30);
    wb(1'b0, 8'hAC, 8'h00);
    chk(q, 8'h20, "clear bit reads zero");
    stable("halt and clear");
    chk(count_o, 16'h0000, "halt and clear value");
    wb(1'b1, 8'hB8, 8'hFF);
    wb(1'b1, 8'hBC, 8'hFF);
    wb(1'b1, 8'hAC, 8'h00);
    // An earlier high read left the low byte latched; unlatch it first.
    wb(1'b0, 8'hB4, 8'h00);
    wb(1'b0, 8'hB0, 8'h00);
    h = tk[7:0];
    chk(q, tk[15:8], "count high byte");
    wb(1'b0, 8'hB0, 8'h00);
    wb(1'b0, 8'hB4, 8'h00);
    chk(q, h, "latched low byte");
    $display("test latch done");
    r6 = 6'($urandom());
    wb(1'b1, 8'hC0, {2'b01, r6});
    chk(c0_o, r6, "channel 0 config");
    wb(1'b1, 8'hC4, {2'b00, ~r6});
    chk(c1_o, 6'(~r6), "channel 1 config");
    chan_event_i <= '{capture: 2'b10, compare: 2'b01};
    @(posedge clk_i);
    chan_event_i <= '0;
    repeat (2) @(posedge clk_i);
    chk({chan_irq_o, wake_o}, 3'b011, "channel irq");
    wb(1'b0, 8'hC4, 8'h00);
    chk(q[7], 1'b1, "channel 1 flag");
    $display("test channel done");
    stop_mode_i <= 1'b1;
    @(posedge clk_i);
    stable("stop mode");
    chk(c0_o, r6, "config kept in stop");
    stop_mode_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(count_o !== s, 1'b1, "resume after stop");
    wait_mode_i <= 1'b1;
    s = count_o;
    repeat (3) @(posedge clk_i);
    chk({count_o !== s, wake_o}, 2'b11, "wait mode runs");
    wait_mode_i <= 1'b0;
    $display("test modes done");
    summarize();
  end
endmodule
